// ---- design/crs_remote_slot.sv ----
`timescale 1ns/1ps
`include "crs_map.svh"

module crs_remote_slot
	import crs_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic cfg_wr,
	input wire logic [`CRS_SLOT_W-1:0] cfg_slot,
	input wire logic [7:0] cfg_ctrl,
	input wire logic [`CRS_ID_W-1:0] cfg_id,
	input wire logic cfg_ext,
	input wire logic [`CRS_ID_W-1:0] id_mask,
	input wire logic mailbox_fifo_mode,
	input wire logic [`CRS_NSLOT-1:0] slot_int_enable,
	input wire logic [`CRS_NSLOT-1:0] slot_irq_clear,
	input wire logic [`CRS_NSLOT-1:0] abort_request,
	input wire logic rx_valid,
	input wire crs_frame_t rx_frame,
	input wire logic intermission,
	input wire logic tx_done,
	input wire logic tx_fail,
	output logic [`CRS_NSLOT-1:0] transfer_in_progress,
	output logic [`CRS_NSLOT-1:0] transfer_finished,
	output logic [`CRS_NSLOT-1:0] remote_active,
	output logic [`CRS_NSLOT-1:0] slot_irq_status,
	output logic irq_request,
	output logic tx_start,
	output logic [`CRS_SLOT_W-1:0] tx_slot,
	output crs_frame_t tx_frame,
	output logic [`CRS_NSLOT-1:0][`CRS_ID_W-1:0] slot_id,
	output logic [`CRS_NSLOT-1:0][`CRS_DLC_W-1:0] slot_dlc,
	output logic [`CRS_NSLOT-1:0][`CRS_TS_W-1:0] slot_time_stamp
);

	crs_state_t state_reg;
	crs_state_t state_next;
	logic [`CRS_NSLOT-1:0] rx_hit_vec;
	logic [`CRS_NSLOT-1:0] tx_pend_vec;
	logic rx_hit;
	logic [`CRS_SLOT_W-1:0] rx_idx;
	logic tx_hit;
	logic [`CRS_SLOT_W-1:0] tx_idx;
	logic reply_ok;
	logic cfg_take;
	logic rx_take;
	logic tx_take;

	// ----------------------------------------
	// per slot acceptance test
	// ----------------------------------------
	generate
		for (genvar g = 0; g < `CRS_NSLOT; g++) begin : g_slot
			assign rx_hit_vec[g] = (state_reg.st[g] == SL_ARMED) &&
				rx_frame.remote &&
				(rx_frame.ext == state_reg.ext[g]) &&
				(((rx_frame.id ^ state_reg.id[g]) & id_mask) == '0);
			assign tx_pend_vec[g] = (state_reg.st[g] == SL_TX_PEND);
		end
	endgenerate

	// search from slot 0 upward, first match takes the frame
	crs_lowest_first u_rx_pick (
		.req(rx_hit_vec),
		.found(rx_hit),
		.idx(rx_idx)
	);

	crs_lowest_first u_tx_pick (
		.req(tx_pend_vec),
		.found(tx_hit),
		.idx(tx_idx)
	);

	assign rx_take = rx_valid && rx_hit && (state_reg.phase == PH_IDLE);
	assign tx_take = intermission && tx_hit && !state_reg.tx_busy;
	// busy slots refuse software writes until the engine lets go
	assign cfg_take = cfg_wr && !state_reg.tip[cfg_slot] &&
		!(state_reg.phase == PH_WRITE && state_reg.cur == cfg_slot);
	// fifo tail slots receive but never answer
	assign reply_ok = !state_reg.inh[state_reg.cur] &&
		!(mailbox_fifo_mode && state_reg.cur >= `CRS_FIFO_FIRST);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.tsc = state_reg.tsc + 1'b1;
		state_next.tx_start = 1'b0;
		state_next.irq_req = 1'b0;
		state_next.irq_st = state_reg.irq_st & ~slot_irq_clear;

		if (cfg_take) begin
			state_next.id[cfg_slot] = cfg_id;
			state_next.ext[cfg_slot] = cfg_ext;
			state_next.tf[cfg_slot] = 1'b0;
			if (cfg_ctrl == `CRS_CTRL_ARM ||
				cfg_ctrl == `CRS_CTRL_ARM_NOREPLY) begin
				state_next.st[cfg_slot] = SL_ARMED;
				state_next.ra[cfg_slot] = 1'b1;
				state_next.inh[cfg_slot] = cfg_ctrl[`CRS_CTRL_INH_BIT];
			end else begin
				state_next.st[cfg_slot] = SL_IDLE;
				state_next.ra[cfg_slot] = 1'b0;
				state_next.inh[cfg_slot] = 1'b0;
			end
		end

		unique case (state_reg.phase)
			PH_IDLE: begin
				// no match: frame dropped, nothing written
				if (rx_take) begin
					state_next.phase = PH_WRITE;
					state_next.cur = rx_idx;
					state_next.tip[rx_idx] = 1'b1;
					state_next.tf[rx_idx] = 1'b1;
					// whole id kept; low part undefined for standard frames
					state_next.id[rx_idx] = rx_frame.id;
					state_next.dlc[rx_idx] = rx_frame.dlc;
					state_next.ts[rx_idx] = state_reg.tsc;
				end
			end
			PH_WRITE: begin
				state_next.phase = PH_IDLE;
				state_next.tip[state_reg.cur] = 1'b0;
				state_next.ra[state_reg.cur] = 1'b0;
				state_next.tf[state_reg.cur] = 1'b0;
				state_next.irq_st[state_reg.cur] = 1'b1;
				state_next.irq_req = slot_int_enable[state_reg.cur];
				if (reply_ok) begin
					state_next.st[state_reg.cur] = SL_TX_PEND;
				end else begin
					state_next.st[state_reg.cur] = SL_IDLE;
				end
			end
		endcase

		if (tx_take) begin
			state_next.tx_busy = 1'b1;
			state_next.tx_start = 1'b1;
			state_next.tx_slot = tx_idx;
			state_next.tip[tx_idx] = 1'b1;
			state_next.st[tx_idx] = SL_TX_BUSY;
		end else if (state_reg.tx_busy && tx_done) begin
			state_next.tx_busy = 1'b0;
			state_next.tip[state_reg.tx_slot] = 1'b0;
			state_next.tf[state_reg.tx_slot] = 1'b1;
			state_next.irq_st[state_reg.tx_slot] = 1'b1;
			state_next.ts[state_reg.tx_slot] = state_reg.tsc;
			// a receive write ending in this cycle keeps its request
			state_next.irq_req = state_next.irq_req |
				slot_int_enable[state_reg.tx_slot];
			state_next.st[state_reg.tx_slot] = SL_IDLE;
		end else if (state_reg.tx_busy && tx_fail) begin
			state_next.tx_busy = 1'b0;
			state_next.tip[state_reg.tx_slot] = 1'b0;
			// retried at a later intermission unless software aborts
			if (abort_request[state_reg.tx_slot]) begin
				state_next.st[state_reg.tx_slot] = SL_IDLE;
			end else begin
				state_next.st[state_reg.tx_slot] = SL_TX_PEND;
			end
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign transfer_in_progress = state_reg.tip;
	assign transfer_finished = state_reg.tf;
	assign remote_active = state_reg.ra;
	assign slot_irq_status = state_reg.irq_st;
	assign irq_request = state_reg.irq_req;
	assign tx_start = state_reg.tx_start;
	assign tx_slot = state_reg.tx_slot;
	assign tx_frame.remote = 1'b0;
	assign tx_frame.ext = state_reg.ext[state_reg.tx_slot];
	assign tx_frame.id = state_reg.id[state_reg.tx_slot];
	assign tx_frame.dlc = state_reg.dlc[state_reg.tx_slot];
	assign slot_id = state_reg.id;
	assign slot_dlc = state_reg.dlc;
	assign slot_time_stamp = state_reg.ts;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_accept;
		rx_valid && rx_hit && state_reg.phase == PH_IDLE;
	endsequence

	sequence s_finish;
		s_accept ##1 state_reg.phase == PH_WRITE;
	endsequence

	sequence s_write;
		state_reg.phase == PH_WRITE;
	endsequence

	sequence s_tx_end;
		state_reg.tx_busy && tx_done;
	endsequence

	// done wins, so a lost transfer is only a fail without done
	sequence s_tx_lost;
		state_reg.tx_busy && tx_fail && !tx_done;
	endsequence

	a_data_frame_ignored:
	assert property (rx_valid && !rx_frame.remote |-> rx_hit_vec == '0)
		else $error("data frame matched a remote slot");

	a_mask_match:
	assert property (s_accept |->
		(((rx_frame.id ^ state_reg.id[rx_idx]) & id_mask) == '0))
		else $error("accepted id differs in a masked-in bit");

	a_format_match:
	assert property (s_accept |-> rx_frame.ext == state_reg.ext[rx_idx])
		else $error("accepted frame has wrong format");

	a_accept_flags:
	assert property (s_accept |=> state_reg.tip[state_reg.cur] &&
		state_reg.tf[state_reg.cur] && state_reg.cur == $past(rx_idx))
		else $error("accept did not set in-progress and finished");

	a_stamp_capture:
	assert property (s_accept |=>
		state_reg.ts[state_reg.cur] == $past(state_reg.tsc))
		else $error("time stamp not captured on accept");

	a_finish_irq:
	assert property (s_finish |=> state_reg.irq_st[$past(state_reg.cur)] &&
		irq_request == ($past(slot_int_enable[state_reg.cur]) ||
		$past(state_reg.tx_busy && tx_done &&
		slot_int_enable[state_reg.tx_slot])))
		else $error("slot interrupt not raised after write");

	a_finish_clear:
	assert property (s_finish |=> !state_reg.ra[$past(state_reg.cur)] &&
		!state_reg.tf[$past(state_reg.cur)] && state_reg.phase == PH_IDLE)
		else $error("remote_active or finished left set");

	a_discard_frame:
	// a software write in the same cycle may change an id legally
	assert property (rx_valid && !rx_hit && !cfg_wr &&
		state_reg.phase == PH_IDLE |=>
		state_reg.phase == PH_IDLE && $stable(state_reg.id))
		else $error("unaccepted frame changed a slot");

	a_tx_lowest:
	assert property (intermission && tx_hit && !state_reg.tx_busy |=>
		tx_start && tx_slot == $past(tx_idx) && transfer_in_progress[tx_slot])
		else $error("wrong transmit slot chosen");

	a_tx_fail_clear:
	assert property (state_reg.tx_busy && tx_fail && !tx_done |=>
		!transfer_in_progress[$past(state_reg.tx_slot)] && !state_reg.tx_busy)
		else $error("failed transmit kept in-progress");

	a_arm_remote:
	assert property (cfg_take && (cfg_ctrl == `CRS_CTRL_ARM ||
		cfg_ctrl == `CRS_CTRL_ARM_NOREPLY) |=>
		remote_active[$past(cfg_slot)])
		else $error("arming write left remote_active clear");

	a_inhibit_idle:
	assert property (s_write ##0 state_reg.inh[state_reg.cur] |=>
		state_reg.st[$past(state_reg.cur)] == SL_IDLE)
		else $error("inhibited slot did not go inactive");

	a_reply_pending:
	assert property (s_write ##0 reply_ok |=>
		state_reg.st[$past(state_reg.cur)] == SL_TX_PEND)
		else $error("reply slot not turned into transmit slot");

	a_fifo_no_reply:
	assert property (s_write ##0
		(mailbox_fifo_mode && state_reg.cur >= `CRS_FIFO_FIRST) |=>
		state_reg.st[$past(state_reg.cur)] != SL_TX_PEND)
		else $error("fifo tail slot set up a reply");

	a_rx_lowest:
	assert property (s_accept |-> rx_hit_vec[rx_idx] &&
		((rx_hit_vec & ((16'h0001 << rx_idx) - 16'h0001)) == '0))
		else $error("frame stored in a slot above a lower match");

	a_tx_no_lower:
	assert property (intermission && tx_hit && !state_reg.tx_busy |->
		tx_pend_vec[tx_idx] &&
		((tx_pend_vec & ((16'h0001 << tx_idx) - 16'h0001)) == '0))
		else $error("lower pending slot skipped");

	a_tx_start_tip:
	assert property (tx_start |-> transfer_in_progress[tx_slot] &&
		state_reg.tx_busy)
		else $error("transmit started without in-progress");

	a_done_finish:
	assert property (s_tx_end |=>
		transfer_finished[$past(state_reg.tx_slot)] &&
		slot_irq_status[$past(state_reg.tx_slot)] &&
		slot_time_stamp[$past(state_reg.tx_slot)] == $past(state_reg.tsc))
		else $error("reply completion not recorded");

	a_done_irq:
	assert property (s_tx_end ##0
		slot_int_enable[state_reg.tx_slot] |=> irq_request)
		else $error("no interrupt request after reply");

	a_done_idle:
	assert property (s_tx_end |=>
		state_reg.st[$past(state_reg.tx_slot)] == SL_IDLE &&
		!transfer_in_progress[$past(state_reg.tx_slot)])
		else $error("slot still active after reply");

	a_abort_idle:
	assert property (s_tx_lost ##0 abort_request[state_reg.tx_slot] |=>
		state_reg.st[$past(state_reg.tx_slot)] == SL_IDLE)
		else $error("abort not honoured after lost transfer");

endmodule // crs_remote_slot

// ---- design/crs_map.svh ----
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define CRS_NSLOT 16
`define CRS_SLOT_W 4
`define CRS_ID_W 29
`define CRS_DLC_W 4
`define CRS_TS_W 16

// ----------------------------------------
// slot control values and fields
// ----------------------------------------
`define CRS_CTRL_ARM 8'h60
`define CRS_CTRL_ARM_NOREPLY 8'h70
`define CRS_CTRL_INH_BIT 4
`define CRS_FIFO_FIRST 4'he

// ----------------------------------------
// reset values
// ----------------------------------------
`define CRS_RST_VEC 16'h0000
`define CRS_RST_TS 16'h0000
`define CRS_RST_SLOT 4'h0

`endif

// ---- design/crs_pkg.sv ----
`include "crs_map.svh"

package crs_pkg;

	typedef enum logic [1:0] {
		SL_IDLE,
		SL_ARMED,
		SL_TX_PEND,
		SL_TX_BUSY
	} crs_slot_st_t;

	typedef enum logic {
		PH_IDLE,
		PH_WRITE
	} crs_phase_t;

	typedef struct packed {
		logic remote;
		logic ext;
		logic [`CRS_ID_W-1:0] id;
		logic [`CRS_DLC_W-1:0] dlc;
	} crs_frame_t;

	typedef struct packed {
		logic [`CRS_NSLOT-1:0][`CRS_ID_W-1:0] id;
		logic [`CRS_NSLOT-1:0] ext;
		logic [`CRS_NSLOT-1:0][`CRS_DLC_W-1:0] dlc;
		logic [`CRS_NSLOT-1:0][`CRS_TS_W-1:0] ts;
		crs_slot_st_t [`CRS_NSLOT-1:0] st;
		logic [`CRS_NSLOT-1:0] tip;
		logic [`CRS_NSLOT-1:0] tf;
		logic [`CRS_NSLOT-1:0] ra;
		logic [`CRS_NSLOT-1:0] inh;
		logic [`CRS_NSLOT-1:0] irq_st;
		crs_phase_t phase;
		logic [`CRS_SLOT_W-1:0] cur;
		logic [`CRS_SLOT_W-1:0] tx_slot;
		logic tx_busy;
		logic tx_start;
		logic irq_req;
		logic [`CRS_TS_W-1:0] tsc;
	} crs_state_t;

endpackage

// ---- design/crs_lowest_first.sv ----
`timescale 1ns/1ps
`include "crs_map.svh"

// ----------------------------------------
// lowest set bit wins
// ----------------------------------------
module crs_lowest_first (
	input wire logic [`CRS_NSLOT-1:0] req,
	output logic found,
	output logic [`CRS_SLOT_W-1:0] idx
);

	always_comb begin
		found = |req;
		idx = `CRS_RST_SLOT;
		// walk downward so the smallest index is written last
		for (int i = `CRS_NSLOT - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = i[`CRS_SLOT_W-1:0];
			end
		end
	end

endmodule // crs_lowest_first

// ---- bench/crs_can_node.sv ----
`timescale 1ns/1ps
`include "crs_map.svh"

// ----------------------------------------
// far-side node: frames, intermission, outcome
// ----------------------------------------
module crs_can_node
	import crs_pkg::*;
(
	input wire logic clock,
	output logic rx_valid,
	output crs_frame_t rx_frame,
	output logic intermission,
	output logic tx_done,
	output logic tx_fail
);
	initial begin
		rx_valid = 1'b0;
		rx_frame = '0;
		intermission = 1'b0;
		tx_done = 1'b0;
		tx_fail = 1'b0;
	end

	// ----------------------------------------
	// bus events, one cycle each
	// ----------------------------------------
	// fields are inverted after the strobe so stale values never match
	task automatic rx(input logic rm, input logic ex,
		input logic [`CRS_ID_W-1:0] id, input logic [3:0] dlc);
		@(negedge clock);
		rx_valid = 1'b1;
		rx_frame = '{remote: rm, ext: ex, id: id, dlc: dlc};
		@(negedge clock);
		rx_valid = 1'b0;
		rx_frame = ~rx_frame;
	endtask

	task automatic im();
		@(negedge clock);
		intermission = 1'b1;
		@(negedge clock);
		intermission = 1'b0;
	endtask

	// lost arbitration and success never come together
	task automatic fin(input logic ok);
		@(negedge clock);
		tx_done = ok;
		tx_fail = !ok;
		@(negedge clock);
		tx_done = 1'b0;
		tx_fail = 1'b0;
	endtask
endmodule // crs_can_node

// ---- bench/crs_remote_slot_tb_top.sv ----
`timescale 1ns/1ps
`include "crs_map.svh"

module crs_remote_slot_tb_top
	import crs_pkg::*;
	;
	localparam logic [28:0] ID = 29'h0abc1234;
	logic clock, rst_n, cfg_wr, cfg_ext, mailbox_fifo_mode, irq_request;
	logic tx_start, rx_valid, intermission, tx_done, tx_fail;
	logic [3:0] cfg_slot, tx_slot;
	logic [7:0] cfg_ctrl;
	logic [28:0] cfg_id, id_mask;
	logic [15:0] slot_int_enable, slot_irq_clear, abort_request;
	logic [15:0] tip, tf, ra, irq_st, ts0;
	crs_frame_t rx_frame, tx_frame;
	logic [15:0][28:0] slot_id;
	logic [15:0][3:0] slot_dlc;
	logic [15:0][15:0] slot_ts;
	int mismatches = 0;
	int n_compared = 0;

	crs_can_node node_u (.clock(clock), .rx_valid(rx_valid),
		.rx_frame(rx_frame), .intermission(intermission),
		.tx_done(tx_done), .tx_fail(tx_fail));

	crs_remote_slot dut_u (.clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr),
		.cfg_slot(cfg_slot), .cfg_ctrl(cfg_ctrl), .cfg_id(cfg_id),
		.cfg_ext(cfg_ext), .id_mask(id_mask),
		.mailbox_fifo_mode(mailbox_fifo_mode),
		.slot_int_enable(slot_int_enable), .slot_irq_clear(slot_irq_clear),
		.abort_request(abort_request), .rx_valid(rx_valid),
		.rx_frame(rx_frame), .intermission(intermission),
		.tx_done(tx_done), .tx_fail(tx_fail),
		.transfer_in_progress(tip), .transfer_finished(tf),
		.remote_active(ra), .slot_irq_status(irq_st),
		.irq_request(irq_request), .tx_start(tx_start), .tx_slot(tx_slot),
		.tx_frame(tx_frame), .slot_id(slot_id), .slot_dlc(slot_dlc),
		.slot_time_stamp(slot_ts));

	initial clock = 1'b0;
	always #2 clock = ~clock;

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic cfg(input logic [3:0] s, input logic [7:0] c,
		input logic ex);
		@(negedge clock);
		cfg_wr = 1'b1;
		cfg_slot = s;
		cfg_ctrl = c;
		cfg_id = ID;
		cfg_ext = ex;
		@(negedge clock);
		cfg_wr = 1'b0;
	endtask

	task automatic summarize;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// tests need under a hundred cycles; the 5000-cycle limit is ample
	initial begin
		#20000;
		mismatches++;
		summarize;
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{rst_n, cfg_wr, cfg_ext, mailbox_fifo_mode, cfg_slot} = '0;
		{cfg_ctrl, cfg_id, slot_irq_clear, abort_request} = '0;
		id_mask = 29'h1ffffffe;
		slot_int_enable = 16'h0008;
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		chk("ra_reset", 16'h0000, ra);
		cfg(4'h3, `CRS_CTRL_ARM, 1'b0);
		cfg(4'h5, `CRS_CTRL_ARM_NOREPLY, 1'b0);
		chk("ra_armed", 16'h0028, ra);
		node_u.rx(1'b0, 1'b0, ID, 4'h2);
		node_u.rx(1'b1, 1'b1, ID, 4'h2);
		node_u.rx(1'b1, 1'b0, ID ^ 29'h2, 4'h2);
		@(negedge clock);
		chk("tip_drop", 16'h0000, tip);
		chk("ra_drop", 16'h0028, ra);
		node_u.rx(1'b1, 1'b0, ID ^ 29'h1, 4'h6);
		chk("tip_rx", 16'h0008, tip);
		chk("tf_rx", 16'h0008, tf);
		chk("id_rx", ID ^ 29'h1, slot_id[3]);
		chk("dlc_rx", 4'h6, slot_dlc[3]);
		ts0 = slot_ts[3];
		@(negedge clock);
		chk("ra_after", 16'h0020, ra);
		chk("tf_after", 16'h0000, tf);
		chk("irqst_rx", 16'h0008, irq_st);
		chk("irq_rx", 1'b1, irq_request);
		slot_irq_clear = 16'h0008;
		@(negedge clock);
		slot_irq_clear = 16'h0000;
		chk("irqst_clr", 16'h0000, irq_st);
		node_u.im();
		chk("tx_start", 1'b1, tx_start);
		chk("tx_slot", 4'h3, tx_slot);
		chk("tx_id", ID ^ 29'h1, tx_frame.id);
		chk("tx_dlc", 4'h6, tx_frame.dlc);
		chk("tip_tx", 16'h0008, tip);
		node_u.fin(1'b0);
		chk("tip_fail", 16'h0000, tip);
		node_u.im();
		chk("tx_retry", 1'b1, tx_start);
		node_u.fin(1'b1);
		chk("tf_done", 16'h0008, tf);
		chk("irqst_done", 16'h0008, irq_st);
		chk("irq_done", 1'b1, irq_request);
		chk("ts_done", ts0 + 16'h000a, slot_ts[3]);
		node_u.im();
		chk("tx_after", 1'b0, tx_start);
		node_u.rx(1'b1, 1'b0, ID, 4'h1);
		chk("tip5", 16'h0020, tip);
		@(negedge clock);
		chk("irq5", 1'b0, irq_request);
		node_u.im();
		chk("tx_inh", 1'b0, tx_start);
		node_u.rx(1'b1, 1'b0, ID, 4'h1);
		chk("tip_inact", 16'h0000, tip);
		mailbox_fifo_mode = 1'b1;
		cfg(4'he, `CRS_CTRL_ARM, 1'b1);
		node_u.rx(1'b1, 1'b1, ID, 4'h3);
		chk("tip14", 16'h4000, tip);
		node_u.im();
		chk("tx_fifo", 1'b0, tx_start);
		cfg(4'h2, `CRS_CTRL_ARM, 1'b0);
		cfg(4'h4, `CRS_CTRL_ARM, 1'b0);
		node_u.rx(1'b1, 1'b0, ID, 4'h4);
		node_u.rx(1'b1, 1'b0, ID, 4'h5);
		chk("tip4", 16'h0010, tip);
		chk("ts_gap", slot_ts[2] + 16'h0002, slot_ts[4]);
		node_u.im();
		chk("tx_pair", 4'h2, tx_slot);
		chk("tx_remote", 1'b0, tx_frame.remote);
		chk("tx_ext", 1'b0, tx_frame.ext);
		abort_request = 16'h0004;
		node_u.fin(1'b0);
		abort_request = 16'h0000;
		chk("tip_abort", 16'h0000, tip);
		node_u.im();
		chk("tx_next", 4'h4, tx_slot);
		chk("tx_dlc5", 4'h5, tx_frame.dlc);
		summarize;
	end
endmodule // crs_remote_slot_tb_top
